// ===== bcod_pkg.sv
// package: encodings, widths and reset values for the branch/call operand decoder
package bcod_pkg;
	localparam int PC_W = 21;
	localparam int TP_W = 21;
	localparam int LAT_W = 8;
	localparam logic [3:0] OP_HI_BR = 4'hE;
	localparam logic [3:0] OP_BZ_SUB = 4'h0;
	localparam logic [6:0] OP_CALL_TOP = 7'h76;
	localparam logic [3:0] OP_CALL_W2 = 4'hF;
	localparam logic [PC_W-1:0] PC_RST = 21'h000000;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	localparam logic [PC_W-1:0] CALL_RET_OFS = 21'h000004;
	localparam logic [TP_W-1:0] TP_RST = 21'h000000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [3:0] BANK_RST = 4'h0;
	localparam logic [1:0] QCNT_RST = 2'h0;
	localparam logic [1:0] Q_LAST = 2'h3;
	localparam int ZERO_BIT = 2;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;

	typedef enum logic [1:0] {
		BCOD_TP_KEEP,
		BCOD_TP_POSTINC,
		BCOD_TP_POSTDEC,
		BCOD_TP_PREINC
	} bcod_tp_mode_t;

	// decoded operand fields of one instruction word
	typedef struct packed {
		logic access_bank;
		logic dest_file;
		logic fast_mode;
		logic [7:0] file_addr;
		logic [1:0] ptr_sel;
		logic [11:0] file_addr12;
		logic [6:0] offset7;
		logic [7:0] lit8;
		logic [11:0] lit12;
	} bcod_fields_t;

	typedef struct packed {
		logic valid;
		logic [15:0] word;
	} bcod_fetch_t;
endpackage : bcod_pkg

// ===== bcod_field_dec.sv
// operand field extraction for one instruction word, plus the 20-bit literal taken from two words
`timescale 1ns/1ps
module bcod_field_dec (
	input wire logic [15:0] word,
	input wire logic [15:0] word2,
	output bcod_pkg::bcod_fields_t fields,
	output logic [19:0] lit20
);
	import bcod_pkg::*;

	assign fields.access_bank = word[8];
	assign fields.dest_file = word[9];
	assign fields.fast_mode = word[8];
	assign fields.file_addr = word[7:0];
	assign fields.ptr_sel = word[1:0];
	assign fields.file_addr12 = word[11:0];
	assign fields.offset7 = word[6:0];
	assign fields.lit8 = word[7:0];
	assign fields.lit12 = word[11:0];
	assign lit20 = {word2[11:0], word[7:0]};
endmodule : bcod_field_dec

// ===== bcod_core.sv
// branch-if-zero, call and operand addressing logic of the core
// =====================================================================
// Overview of operation
// - E0 nn branches when zero flag set
// - target is branch address plus 2 plus 2n
// - one cycle, two when taken; flags kept
// - fast bit copies working/status/bank to shadows
// - access bit zero ignores bank select
// - destination bit picks working or file register
// - table pointer keep, post-inc, post-dec, pre-inc
// - table pointer 21 bits, latch 8 bits
// - short operand 8-bit address or 2-bit pointer
// - move operands are full 12-bit addresses
// - indexed moves add 7-bit offset to pointer
// - literals of 8, 12 or 20 bits
`timescale 1ns/1ps
module bcod_core #(
	parameter int STACK_DEPTH = 31
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input bcod_pkg::bcod_fetch_t fetch,
	input wire logic [15:0] fetch_word2,
	input wire logic [7:0] status_in,
	input wire logic [7:0] working_in,
	input wire logic [3:0] bank_in,
	input wire logic [11:0] ptr_in,
	input wire logic tbl_req,
	input wire bcod_pkg::bcod_tp_mode_t tbl_mode,
	input wire logic [7:0] tbl_data_in,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [bcod_pkg::PC_W-1:0] pc,
	output logic [bcod_pkg::PC_W-1:0] stack_top,
	output logic idle_cycle,
	output logic [11:0] data_addr,
	output logic dest_is_file,
	output logic [7:0] working_shadow,
	output logic [7:0] status_shadow,
	output logic [3:0] bank_select_shadow,
	output logic [bcod_pkg::TP_W-1:0] table_pointer,
	output logic [7:0] table_latch,
	output logic [7:0] status_out
);
	import bcod_pkg::*;

	// =================================================================
	// register port map
	localparam logic [7:0] REG_PC = 8'h00;
	localparam logic [7:0] REG_TP = 8'h04;
	localparam logic [7:0] REG_TL = 8'h08;
	localparam logic [7:0] REG_ST = 8'h0C;

	// =================================================================
	// decode
	bcod_fields_t fields;
	logic [19:0] lit20;
	bcod_field_dec u_dec (
		.word(fetch.word),
		.word2(fetch_word2),
		.fields(fields),
		.lit20(lit20)
	);

	logic [1:0] q_r;
	logic busy_r;
	wire q_end = (q_r == Q_LAST);
	wire issue = q_end && fetch.valid && !busy_r;
	wire is_bz = (fetch.word[15:12] == OP_HI_BR) && (fetch.word[11:8] == OP_BZ_SUB);
	wire is_call = (fetch.word[15:9] == OP_CALL_TOP) && (fetch_word2[15:12] == OP_CALL_W2);
	wire zero_set = status_in[ZERO_BIT];
	wire bz_taken = issue && is_bz && zero_set;
	wire do_call = issue && is_call;
	wire [PC_W-1:0] n_ext = {{(PC_W-8){fields.lit8[7]}}, fields.lit8};
	wire [PC_W-1:0] bz_target = pc + PC_STEP + {n_ext[PC_W-2:0], 1'b0};
	wire [PC_W-1:0] call_target = {lit20, 1'b0};
	wire [PC_W-1:0] call_ret = pc + CALL_RET_OFS;

	// access ram below 0x60 maps to bank 0, the rest to the top bank
	wire [11:0] access_addr = (fields.file_addr < ACCESS_SPLIT) ?
		{4'h0, fields.file_addr} : {4'hF, fields.file_addr};
	wire [11:0] banked_addr = fields.access_bank ? {bank_in, fields.file_addr}
		: access_addr;
	wire [11:0] indexed_addr = ptr_in + {5'h00, fields.offset7};

	// =================================================================
	// quarter-cycle and program counter
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			q_r <= QCNT_RST;
		end else begin
			q_r <= q_r + 2'h1;
		end
	end

	// taken branch and call both add one idle instruction cycle
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			busy_r <= 1'b0;
			idle_cycle <= 1'b0;
		end else if (q_end) begin
			busy_r <= bz_taken || do_call;
			idle_cycle <= busy_r;
		end
	end

	logic [PC_W-1:0] pc_nxt;
	always_comb begin
		pc_nxt = pc;
		if (bz_taken) begin
			pc_nxt = bz_target;
		end else if (do_call) begin
			pc_nxt = call_target;
		end else if (issue) begin
			pc_nxt = pc + PC_STEP;
		end
	end

	logic [PC_W-1:0] stack_r [STACK_DEPTH];
	logic [4:0] sp_r;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pc <= PC_RST;
			stack_top <= PC_RST;
			sp_r <= 5'h00;
		end else begin
			pc <= pc_nxt;
			if (do_call) begin
				stack_top <= call_ret;
				stack_r[sp_r] <= stack_top;
				sp_r <= sp_r + 5'h01;
			end
		end
	end

	// =================================================================
	// shadows, addressing, status passthrough
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			working_shadow <= BYTE_RST;
			status_shadow <= BYTE_RST;
			bank_select_shadow <= BANK_RST;
		end else if (do_call && fields.fast_mode) begin
			working_shadow <= working_in;
			status_shadow <= status_in;
			bank_select_shadow <= bank_in;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			data_addr <= 12'h000;
			dest_is_file <= 1'b0;
			status_out <= BYTE_RST;
		end else begin
			status_out <= status_in;
			if (issue) begin
				dest_is_file <= fields.dest_file;
				data_addr <= banked_addr;
			end else if (fetch.valid && q_end) begin
				data_addr <= fields.file_addr12;
			end else begin
				data_addr <= indexed_addr;
			end
		end
	end

	// =================================================================
	// table pointer and latch
	wire tp_wr = reg_wr && (reg_addr == REG_TP);
	wire tl_wr = reg_wr && (reg_addr == REG_TL);
	logic [TP_W-1:0] tp_nxt;
	always_comb begin
		tp_nxt = table_pointer;
		if (tbl_req) begin
			unique case (tbl_mode)
				BCOD_TP_KEEP: tp_nxt = table_pointer;
				BCOD_TP_POSTINC: tp_nxt = table_pointer + 21'h000001;
				BCOD_TP_POSTDEC: tp_nxt = table_pointer - 21'h000001;
				BCOD_TP_PREINC: tp_nxt = table_pointer + 21'h000001;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			table_pointer <= TP_RST;
			table_latch <= BYTE_RST;
		end else begin
			if (tp_wr) begin
				table_pointer <= reg_wdata[TP_W-1:0];
			end else begin
				table_pointer <= tp_nxt;
			end
			if (tbl_req) begin
				table_latch <= tbl_data_in;
			end else if (tl_wr) begin
				table_latch <= reg_wdata[LAT_W-1:0];
			end
		end
	end

	// =================================================================
	// register read port
	wire [31:0] rd_mux = (reg_addr == REG_PC) ? {11'h000, pc} :
		(reg_addr == REG_TP) ? {11'h000, table_pointer} :
		(reg_addr == REG_TL) ? {24'h000000, table_latch} :
		(reg_addr == REG_ST) ? {30'h00000000, idle_cycle, busy_r} : 32'h00000000;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// =================================================================
	// checks
	property p_bz_target;
		@(posedge sys_clk) disable iff (!resetn)
		bz_taken |=> (pc == $past(bz_target));
	endproperty
	a_bz_target: assert property (p_bz_target) else $error("branch target wrong");

	property p_bz_not;
		@(posedge sys_clk) disable iff (!resetn)
		(issue && is_bz && !zero_set) |=> (pc == $past(pc) + PC_STEP);
	endproperty
	a_bz_not: assert property (p_bz_not) else $error("untaken branch moved pc wrong");

	property p_bz_idle;
		@(posedge sys_clk) disable iff (!resetn)
		bz_taken |-> ##4 (!issue ##1 idle_cycle);
	endproperty
	a_bz_idle: assert property (p_bz_idle) else $error("no idle after taken branch");

	property p_call_push;
		@(posedge sys_clk) disable iff (!resetn)
		do_call |=> (stack_top == $past(pc) + CALL_RET_OFS);
	endproperty
	a_call_push: assert property (p_call_push) else $error("call return address wrong");

	property p_call_idle;
		@(posedge sys_clk) disable iff (!resetn)
		do_call |-> ##4 (!issue ##1 idle_cycle);
	endproperty
	a_call_idle: assert property (p_call_idle) else $error("call second cycle not idle");

	property p_shadow_keep;
		@(posedge sys_clk) disable iff (!resetn)
		!(do_call && fields.fast_mode) |=> $stable(working_shadow);
	endproperty
	a_shadow_keep: assert property (p_shadow_keep) else $error("shadow changed");

	property p_tp_inc;
		@(posedge sys_clk) disable iff (!resetn)
		(tbl_req && !tp_wr && tbl_mode == BCOD_TP_POSTINC) |=>
			(table_pointer == $past(table_pointer) + 21'h000001);
	endproperty
	a_tp_inc: assert property (p_tp_inc) else $error("table pointer not incremented");

	property p_rd_lat;
		@(posedge sys_clk) disable iff (!resetn)
		(reg_rd && reg_addr == REG_PC) |=> (reg_rdata[PC_W-1:0] == $past(pc));
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data wrong");

	property p_access_addr;
		@(posedge sys_clk) disable iff (!resetn)
		(issue && !fields.access_bank) |=> (data_addr[7:0] == $past(fields.file_addr)) &&
			(data_addr[11:8] == 4'h0 || data_addr[11:8] == 4'hF);
	endproperty
	a_access_addr: assert property (p_access_addr) else $error("access address wrong");

	property p_bank_addr;
		@(posedge sys_clk) disable iff (!resetn)
		(issue && fields.access_bank) |=> (data_addr == {$past(bank_in), $past(fields.file_addr)});
	endproperty
	a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong");

	property p_dest;
		@(posedge sys_clk) disable iff (!resetn)
		issue |=> (dest_is_file == $past(fields.dest_file));
	endproperty
	a_dest: assert property (p_dest) else $error("destination select wrong");

	property p_move_addr;
		@(posedge sys_clk) disable iff (!resetn)
		(q_end && fetch.valid && busy_r) |=> (data_addr == $past(fields.file_addr12));
	endproperty
	a_move_addr: assert property (p_move_addr) else $error("move address wrong");

	property p_idx_addr;
		@(posedge sys_clk) disable iff (!resetn)
		!q_end |=> (data_addr == $past(ptr_in) + {5'h00, $past(fields.offset7)});
	endproperty
	a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong");

	property p_tp_dec;
		@(posedge sys_clk) disable iff (!resetn)
		(tbl_req && !tp_wr && tbl_mode == BCOD_TP_POSTDEC) |=>
			(table_pointer == $past(table_pointer) - 21'h000001);
	endproperty
	a_tp_dec: assert property (p_tp_dec) else $error("table pointer not decremented");

	property p_tl_load;
		@(posedge sys_clk) disable iff (!resetn)
		tbl_req |=> (table_latch == $past(tbl_data_in));
	endproperty
	a_tl_load: assert property (p_tl_load) else $error("table latch not loaded");
endmodule : bcod_core

// ===== branch_call_operand_decode_tb_top.sv
// self-checking testbench for the branch/call operand decoder
`timescale 1ns/1ps
module branch_call_operand_decode_tb_top;
	import bcod_pkg::*;
	logic sys_clk, resetn, tbl_req, reg_wr, reg_rd;
	bcod_fetch_t fetch;
	logic [15:0] fetch_word2;
	logic [11:0] ptr_in, seen_addr, seen_idx, exp_addr;
	logic [7:0] status_in, working_in, tbl_data_in, reg_addr;
	logic [3:0] bank_in;
	bcod_tp_mode_t tbl_mode;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic [PC_W-1:0] pc, stack_top, table_pointer, exp_pc;
	logic idle_cycle, dest_is_file;
	logic [11:0] data_addr;
	logic [7:0] working_shadow, status_shadow, table_latch, status_out;
	logic [3:0] bank_select_shadow;
	int err_total, comparisons;
	// branch rows: {zero flag, offset}
	logic [8:0] bz_rows [6] = '{9'h17F, 9'h180, 9'h1FF, 9'h100, 9'h07F, 9'h080};
	// operand rows: {dest bit, access bit, file address}
	logic [9:0] da_rows [4] = '{10'h05F, 10'h060, 10'h112, 10'h3FF};

	bcod_core dut (.sys_clk, .resetn, .fetch, .fetch_word2, .status_in, .working_in, .bank_in,
		.ptr_in, .tbl_req, .tbl_mode, .tbl_data_in, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .pc, .stack_top, .idle_cycle, .data_addr, .dest_is_file,
		.working_shadow, .status_shadow, .bank_select_shadow, .table_pointer, .table_latch,
		.status_out);

	// =====================================================================
	// shared tasks
	task stop_test;
		if (err_total == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	task chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("Error %0t: %s", $time, m);
		end
	endtask : chk

	// one instruction slot: offered before a quarter-3 edge, returns after the fourth edge;
	// data_addr stands one cycle only, so it is caught after the first two edges
	task issue(input logic [15:0] a, input logic [15:0] b);
		fetch <= {1'b1, a};
		fetch_word2 <= b;
		@(posedge sys_clk);
		@(negedge sys_clk);
		seen_addr = data_addr;
		@(negedge sys_clk);
		seen_idx = data_addr;
		repeat (2) @(posedge sys_clk);
	endtask : issue

	task reg_write(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task reg_read(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
		@(posedge sys_clk);
	endtask : reg_read

	// a call offered during the idle slot must be dropped
	task do_call(input logic s, input logic [19:0] k);
		exp_pc = pc + CALL_RET_OFS;
		issue({OP_CALL_TOP, s, k[7:0]}, {OP_CALL_W2, k[19:8]});
		chk(pc === {k, 1'b0}, "call target");
		chk(pc[20:9] === k[19:8] && pc[8:1] === k[7:0], "long literal");
		chk(stack_top === exp_pc, "return address");
		issue({OP_CALL_TOP, 1'b1, 8'h00}, {OP_CALL_W2, 12'h000});
		chk(idle_cycle === 1'b1 && pc === {k, 1'b0}, "call idle cycle");
	endtask : do_call

	// =====================================================================
	// clock, watchdog and main sequence
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		#20000;
		err_total++;
		$display("Error %0t: watchdog expired", $time);
		stop_test();
	end

	initial begin
		resetn = 1'b0;
		fetch = '0;
		fetch_word2 = 16'h0000;
		ptr_in = 12'hFC0;
		{status_in, working_in, tbl_data_in, reg_addr, bank_in} = {8'h00, 8'hE1, 20'h00000};
		{tbl_req, reg_wr, reg_rd, reg_wdata} = '0;
		tbl_mode = BCOD_TP_KEEP;
		err_total = 0;
		comparisons = 0;
		repeat (8) @(posedge sys_clk);
		chk(pc === PC_RST && table_pointer === TP_RST && idle_cycle === 1'b0, "reset values");
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < 6; i++) begin
			exp_pc = pc + PC_STEP;
			if (bz_rows[i][8])
				exp_pc = exp_pc + {{12{bz_rows[i][7]}}, bz_rows[i][7:0], 1'b0};
			status_in <= {5'h15, bz_rows[i][8], 2'b01};
			issue({OP_HI_BR, OP_BZ_SUB, bz_rows[i][7:0]}, 16'h0000);
			chk(pc === exp_pc, "branch target");
			chk(status_out === status_in && idle_cycle === 1'b0, "branch flags");
			exp_addr = {(bz_rows[i][7:0] < ACCESS_SPLIT) ? 4'h0 : 4'hF, bz_rows[i][7:0]};
			chk(seen_addr === exp_addr, "short operand");
			chk(seen_idx === ptr_in + {5'h00, bz_rows[i][6:0]}, "indexed address");
			if (bz_rows[i][8]) begin
				issue({OP_CALL_TOP, 1'b1, bz_rows[i][7:0]}, {OP_CALL_W2, 12'h000});
				chk(idle_cycle === 1'b1 && pc === exp_pc, "taken branch idle");
				chk(seen_addr === {OP_CALL_TOP[2:0], 1'b1, bz_rows[i][7:0]}, "move operand");
			end
		end
		chk(working_shadow === BYTE_RST, "dropped call touched shadow");
		{working_in, bank_in} <= {8'h3C, 4'h9};
		status_in <= 8'h5A;
		do_call(1'b0, 20'h81234);
		chk({working_shadow, status_shadow, bank_select_shadow} === 20'h0, "shadow kept");
		do_call(1'b1, 20'hFFFFF);
		chk({working_shadow, status_shadow, bank_select_shadow} === 20'h3C5A9, "shadow");
		working_in <= 8'h77;
		do_call(1'b0, 20'h00001);
		chk(working_shadow === 8'h3C, "shadow overwritten");
		for (int i = 0; i < 4; i++) begin
			ptr_in <= {da_rows[i][7:0], 4'h5};
			issue({6'b001001, da_rows[i]}, 16'h0000);
			exp_pc[11:0] = da_rows[i][8] ? {bank_in, da_rows[i][7:0]} :
				{(da_rows[i][7:0] < ACCESS_SPLIT) ? 4'h0 : 4'hF, da_rows[i][7:0]};
			chk(seen_addr === exp_pc[11:0], "data address");
			chk(seen_idx === ptr_in + {5'h00, da_rows[i][6:0]}, "indexed address");
			chk(dest_is_file === da_rows[i][9], "destination");
		end
		fetch <= '0;
		// all-ones start shows the pointer wraps at 21 bits
		for (int m = 0; m < 4; m++) begin
			reg_write(8'h04, 32'h001FFFFF);
			tbl_mode <= bcod_tp_mode_t'(m);
			tbl_data_in <= 8'hC0 + 8'(m);
			tbl_req <= 1'b1;
			@(posedge sys_clk);
			tbl_req <= 1'b0;
			@(posedge sys_clk);
			exp_pc = (m == 0) ? 21'h1FFFFF : (m == 2) ? 21'h1FFFFE : 21'h000000;
			chk(table_pointer === exp_pc && table_latch === 8'hC0 + 8'(m), "table mode");
			reg_read(8'h04, rd);
			chk(rd === {11'h000, exp_pc}, "pointer readback");
		end
		reg_read(8'h08, rd);
		chk(rd === 32'h000000C3, "latch readback");
		reg_read(8'h10, rd);
		chk(rd === 32'h00000000, "unmapped read");
		exp_pc = pc;
		reg_write(8'h00, 32'h0000FFFF);
		reg_read(8'h00, rd);
		chk(rd === {11'h000, exp_pc}, "pc read-only");
		resetn <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk(pc === PC_RST && table_pointer === TP_RST && table_latch === BYTE_RST, "reset again");
		stop_test();
	end
endmodule : branch_call_operand_decode_tb_top
